// ===== hdl/gmsr_consts.vh
/*
 * Constants for the gigabit role control and status register pair: register
 * indices, field positions, reset values and test mode encodings.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef GMSR_CONSTS_VH
`define GMSR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices on the management interface
// ----------------------------------------------------------------------------
`define GMSR_IDX_CTRL 5'h09
`define GMSR_IDX_STAT 5'h0a
`define GMSR_IDX_EXP 5'h06

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define GMSR_C_TEST_HI 15
`define GMSR_C_TEST_LO 13
`define GMSR_C_MANEN 12
`define GMSR_C_MANVAL 11
`define GMSR_C_PORTTYPE 10
`define GMSR_C_ADVFD 9
`define GMSR_C_ADVHD 8

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define GMSR_S_FAULT 15
`define GMSR_S_ROLE 14
`define GMSR_S_LOCRX 13
`define GMSR_S_REMRX 12
`define GMSR_S_LPFD 11
`define GMSR_S_LPHD 10
`define GMSR_S_IDLE_HI 7
`define GMSR_S_IDLE_LO 0

// ----------------------------------------------------------------------------
// Expansion register page-received bit
// ----------------------------------------------------------------------------
`define GMSR_E_PAGERX 1

// ----------------------------------------------------------------------------
// Test mode codes and reset values
// ----------------------------------------------------------------------------
`define GMSR_TM_NORMAL 3'h0
`define GMSR_TM_WAVE 3'h1
`define GMSR_TM_MJIT 3'h2
`define GMSR_TM_SJIT 3'h3
`define GMSR_TM_DIST 3'h4
`define GMSR_IDLE_ZERO 8'h00
`define GMSR_IDLE_FULL 8'hff
`define GMSR_WORD_ZERO 16'h0000

`endif

// ===== hdl/gmsr_idle_counter.v
/*
 * Saturating idle error counter with clear on read.
 * Assumes errEvent, readClear and logicReset are on the mclk domain.
 */
`default_nettype none
`include "gmsr_consts.vh"

module gmsr_idle_counter #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire logicReset,
    input wire readClear,
    input wire errEvent,
    output reg [WIDTH-1:0] count_q,
    output reg overflow_q
);

    wire isFull;

    assign isFull = &count_q;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // A read clears the count; an error in the same cycle counts as one, so
    // the event is not lost.
    always @(posedge mclk) begin
        overflow_q <= 1'b0;
        if (!rst_n || logicReset) begin
            count_q <= {WIDTH{1'b0}};
        end else if (readClear) begin
            count_q <= errEvent ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        end else if (errEvent) begin
            if (isFull) begin
                overflow_q <= 1'b1;
            end else begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // gmsr_idle_counter
`default_nettype wire

// ===== hdl/gmsr_regs.v
/*
 * Gigabit master/slave control and status registers behind the serial
 * management register port, plus the latched page-received flag.
 * Assumes a management decoder on mclk giving one-cycle read and write
 * strobes with a register index; PHY core status inputs are asynchronous
 * and are synchronised here; strap pins are steady around reset release.
 */
`default_nettype none
`include "gmsr_consts.vh"

module gmsr_regs #(
    parameter IDLE_WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire [4:0] regIndex,
    input wire regWrite,
    input wire regRead,
    input wire [15:0] regWdata,
    output reg [15:0] regRdata_q,
    input wire [1:0] modeStrap,
    input wire logicReset,
    input wire faultPin,
    input wire roleMasterPin,
    input wire localRxOkPin,
    input wire remoteRxOkPin,
    input wire partner_gig_full_duplex,
    input wire partner_gig_half_duplex,
    input wire pageArrivedPin,
    input wire idleErrPin,
    output reg [2:0] testMode_q,
    output reg testWave_q,
    output reg testMasterJitter_q,
    output reg testSlaveJitter_q,
    output reg testDistortion_q,
    output reg forceRole_q,
    output reg forceMaster_q,
    output reg multiPort_q,
    output reg advFull_q,
    output reg advHalf_q,
    output reg idleOverflowIrq_q
);

    localparam NSYNC = 8;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    wire [NSYNC-1:0] asyncIn;
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    reg idlePrev_q;

    assign asyncIn = {idleErrPin, pageArrivedPin, partner_gig_half_duplex,
                      partner_gig_full_duplex, remoteRxOkPin, localRxOkPin,
                      roleMasterPin, faultPin};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : gSync
            always @(posedge mclk) begin
                if (!rst_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= asyncIn[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire faultNow = sync2_q[0];
    wire roleMaster = sync2_q[1];
    wire localRxOk = sync2_q[2];
    wire remoteRxOk = sync2_q[3];
    wire lpFull = sync2_q[4];
    wire lpHalf = sync2_q[5];
    wire pageArrived = sync2_q[6];
    wire idleErrLevel = sync2_q[7];
    wire idleErrEvent = idleErrLevel & ~idlePrev_q;

    // ------------------------------------------------------------------------
    // Access decoding
    // ------------------------------------------------------------------------
    function hit;
        input [4:0] idx;
        input [4:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    wire wrCtrl = regWrite && hit(regIndex, `GMSR_IDX_CTRL);
    wire rdStat = regRead && hit(regIndex, `GMSR_IDX_STAT);
    wire rdExp = regRead && hit(regIndex, `GMSR_IDX_EXP);

    // ------------------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------------------
    reg inReset_q;
    always @(posedge mclk) begin
        inReset_q <= !rst_n;
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            testMode_q <= `GMSR_TM_NORMAL;
            forceRole_q <= 1'b0;
            forceMaster_q <= 1'b0;
            multiPort_q <= 1'b0;
            advFull_q <= 1'b0;
            advHalf_q <= 1'b0;
        end else if (inReset_q) begin
            forceRole_q <= 1'b0;
            forceMaster_q <= modeStrap[1];
            multiPort_q <= modeStrap[1];
            advFull_q <= modeStrap[0];
            advHalf_q <= modeStrap[0];
        end else if (wrCtrl) begin
            testMode_q <= regWdata[`GMSR_C_TEST_HI:`GMSR_C_TEST_LO];
            forceRole_q <= regWdata[`GMSR_C_MANEN];
            forceMaster_q <= regWdata[`GMSR_C_MANVAL];
            multiPort_q <= regWdata[`GMSR_C_PORTTYPE];
            advFull_q <= regWdata[`GMSR_C_ADVFD];
            advHalf_q <= regWdata[`GMSR_C_ADVHD];
        end
    end

    // Test mode strobes; reserved codes select no test.
    always @(posedge mclk) begin
        if (!rst_n) begin
            testWave_q <= 1'b0;
            testMasterJitter_q <= 1'b0;
            testSlaveJitter_q <= 1'b0;
            testDistortion_q <= 1'b0;
        end else begin
            testWave_q <= (testMode_q == `GMSR_TM_WAVE);
            testMasterJitter_q <= (testMode_q == `GMSR_TM_MJIT);
            testSlaveJitter_q <= (testMode_q == `GMSR_TM_SJIT);
            testDistortion_q <= (testMode_q == `GMSR_TM_DIST);
        end
    end

    // ------------------------------------------------------------------------
    // Latched-high status
    // ------------------------------------------------------------------------
    reg fault_q;
    reg pageRx_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
            pageRx_q <= 1'b0;
            idlePrev_q <= 1'b0;
        end else begin
            idlePrev_q <= idleErrLevel;
            if (faultNow) begin
                fault_q <= 1'b1;
            end else if (rdStat) begin
                fault_q <= 1'b0;
            end
            if (pageArrived) begin
                pageRx_q <= 1'b1;
            end else if (rdExp) begin
                pageRx_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Idle error counter
    // ------------------------------------------------------------------------
    wire [IDLE_WIDTH-1:0] idleCount;
    wire idleOverflow;

    gmsr_idle_counter #(
        .WIDTH(IDLE_WIDTH)
    ) uIdle (
        .mclk(mclk),
        .rst_n(rst_n),
        .logicReset(logicReset),
        .readClear(rdStat),
        .errEvent(idleErrEvent),
        .count_q(idleCount),
        .overflow_q(idleOverflow)
    );

    always @(posedge mclk) begin
        if (!rst_n) begin
            idleOverflowIrq_q <= 1'b0;
        end else begin
            idleOverflowIrq_q <= idleOverflow;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    reg [15:0] rdMux;
    always @* begin
        rdMux = `GMSR_WORD_ZERO;
        if (hit(regIndex, `GMSR_IDX_CTRL)) begin
            rdMux[`GMSR_C_TEST_HI:`GMSR_C_TEST_LO] = testMode_q;
            rdMux[`GMSR_C_MANEN] = forceRole_q;
            rdMux[`GMSR_C_MANVAL] = forceMaster_q;
            rdMux[`GMSR_C_PORTTYPE] = multiPort_q;
            rdMux[`GMSR_C_ADVFD] = advFull_q;
            rdMux[`GMSR_C_ADVHD] = advHalf_q;
        end else if (hit(regIndex, `GMSR_IDX_STAT)) begin
            rdMux[`GMSR_S_FAULT] = fault_q;
            rdMux[`GMSR_S_ROLE] = roleMaster;
            rdMux[`GMSR_S_LOCRX] = localRxOk;
            rdMux[`GMSR_S_REMRX] = remoteRxOk;
            rdMux[`GMSR_S_LPFD] = lpFull;
            rdMux[`GMSR_S_LPHD] = lpHalf;
            rdMux[`GMSR_S_IDLE_HI:`GMSR_S_IDLE_LO] = idleCount[7:0];
        end else if (hit(regIndex, `GMSR_IDX_EXP)) begin
            rdMux[`GMSR_E_PAGERX] = pageRx_q;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            regRdata_q <= `GMSR_WORD_ZERO;
        end else if (regRead) begin
            regRdata_q <= rdMux;
        end
    end

endmodule // gmsr_regs
`default_nettype wire

// ===== tb/gmsr_regs_chk.sv
/* Concurrent checks on the ports of gmsr_regs.
   Assumes a bind onto gmsr_regs, one clock mclk and synchronous rst_n. */
`default_nettype none
module gmsr_regs_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [4:0] regIndex,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata_q,
    input wire logic [1:0] modeStrap,
    input wire logic faultPin,
    input wire logic [2:0] testMode_q,
    input wire logic testWave_q,
    input wire logic testMasterJitter_q,
    input wire logic testSlaveJitter_q,
    input wire logic testDistortion_q,
    input wire logic forceRole_q,
    input wire logic forceMaster_q,
    input wire logic multiPort_q,
    input wire logic advFull_q,
    input wire logic advHalf_q,
    input wire logic idleOverflowIrq_q
);
    timeunit 1ns;
    timeprecision 100ps;
    wire [7:0] ctrl = {testMode_q, forceRole_q, forceMaster_q, multiPort_q, advFull_q, advHalf_q};
    wire [3:0] dec = {testMode_q == 3'h1, testMode_q == 3'h2, testMode_q == 3'h3,
        testMode_q == 3'h4};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wr_ctrl_a: assert property (
        regWrite && regIndex == 5'h09 |=> ctrl == $past(regWdata[15:8]))
        else $error("control write not applied");
    test_decode_a: assert property (
        1 |=> {testWave_q, testMasterJitter_q, testSlaveJitter_q, testDistortion_q} == $past(dec))
        else $error("test strobes do not match test mode");
    strap_load_a: assert property (
        $rose(rst_n) |=> ctrl == {4'h0, {2{$past(modeStrap[1])}}, {2{$past(modeStrap[0])}}})
        else $error("strap defaults wrong");
    ctrl_read_a: assert property (
        regRead && regIndex == 5'h09 |=> regRdata_q == {$past(ctrl), 8'h00})
        else $error("control readback wrong");
    stat_rsvd_a: assert property (
        regRead && regIndex == 5'h0a |=> regRdata_q[9:8] == 2'h0)
        else $error("status reserved bits set");
    ctrl_hold_a: assert property (
        !(regWrite && regIndex == 5'h09) && !$rose(rst_n) |=> $stable(ctrl))
        else $error("control changed without write");
    rdata_hold_a: assert property (
        !regRead |=> $stable(regRdata_q))
        else $error("read data changed without read");
    fault_seen_a: assert property (
        faultPin [*4] ##1 (regRead && regIndex == 5'h0a) |=> regRdata_q[15])
        else $error("fault not reported");
    irq_pulse_a: assert property (
        idleOverflowIrq_q |=> !idleOverflowIrq_q)
        else $error("overflow pulse too long");
    cover property (regWrite && regIndex == 5'h09 && regWdata[15:13] == 3'h4);
    cover property (idleOverflowIrq_q);
    cover property (regRead && regIndex == 5'h06);
endmodule // gmsr_regs_chk
bind gmsr_regs gmsr_regs_chk gmsr_regs_chk_i (.*);
`default_nettype wire

// ===== tb/gmsr_smi_model.sv
/* Management station model issuing one-cycle register strobes.
   Assumes mclk from the bench; requests are taken on the rising edge. */
`default_nettype none
module gmsr_smi_model (
    input wire logic mclk,
    input wire logic [15:0] regRdata_q,
    output logic [4:0] regIndex,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regWdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        regIndex = 5'h00;
        regWrite = 1'h0;
        regRead = 1'h0;
        regWdata = 16'h0000;
    end
    task automatic wr(input logic [4:0] idx, input logic [15:0] data);
        @(posedge mclk);
        regIndex <= idx;
        regWdata <= data;
        regWrite <= 1'h1;
        @(posedge mclk);
        regWrite <= 1'h0;
        // Stale write data is scrambled so a late sample cannot pass.
        regWdata <= ~data;
    endtask
    task automatic rd(input logic [4:0] idx, output logic [15:0] data);
        @(posedge mclk);
        regIndex <= idx;
        regRead <= 1'h1;
        @(posedge mclk);
        regRead <= 1'h0;
        // The registered answer stands until the next read, so take it at the next edge.
        @(posedge mclk);
        data = regRdata_q;
    endtask
endmodule // gmsr_smi_model
`default_nettype wire

// ===== tb/gmsr_regs_tb_top.sv
/* Self-checking bench for gmsr_regs through the management model.
   Assumes the design, the model and the checker are compiled first. */
`default_nettype none
module gmsr_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [1:0] modeStrap = 2'h2;
    logic logicReset = 1'h0;
    logic [7:0] pins = 8'h00;
    logic [15:0] w;
    int miscompares = 0, totalChecks = 0, irqCount = 0, irqBase = 0;
    wire [4:0] regIndex;
    wire regWrite, regRead, idleOverflowIrq_q;
    wire [15:0] regWdata, regRdata_q;
    wire [2:0] testMode_q;
    wire [3:0] strobe;
    wire [4:0] ctrlBits;
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (idleOverflowIrq_q === 1'h1) irqCount <= irqCount + 1;
    gmsr_smi_model gmsr_smi_model_i (.mclk(mclk), .regRdata_q(regRdata_q), .regIndex(regIndex),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
    gmsr_regs #(.IDLE_WIDTH(8)) gmsr_regs_i (.mclk(mclk), .rst_n(rst_n), .regIndex(regIndex),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .modeStrap(modeStrap), .logicReset(logicReset), .faultPin(pins[0]),
        .roleMasterPin(pins[1]), .localRxOkPin(pins[2]), .remoteRxOkPin(pins[3]),
        .partner_gig_full_duplex(pins[4]), .partner_gig_half_duplex(pins[5]),
        .pageArrivedPin(pins[6]), .idleErrPin(pins[7]), .testMode_q(testMode_q),
        .testWave_q(strobe[3]), .testMasterJitter_q(strobe[2]), .testSlaveJitter_q(strobe[1]),
        .testDistortion_q(strobe[0]), .forceRole_q(ctrlBits[4]), .forceMaster_q(ctrlBits[3]),
        .multiPort_q(ctrlBits[2]), .advFull_q(ctrlBits[1]), .advHalf_q(ctrlBits[0]),
        .idleOverflowIrq_q(idleOverflowIrq_q));
    task automatic print_verdict;
        if (miscompares == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [4:0] idx, input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] d;
        gmsr_smi_model_i.rd(idx, d);
        chk(d & mask, exp);
    endtask
    task automatic doReset(input logic [1:0] strap);
        @(posedge mclk);
        rst_n <= 1'h0;
        modeStrap <= strap;
        tick(3);
        rst_n <= 1'h1;
        tick(2);
    endtask
    task automatic pulseErr(input int n);
        repeat (n) begin
            @(posedge mclk);
            pins[7] <= 1'h1;
            tick(2);
            pins[7] <= 1'h0;
            @(posedge mclk);
        end
        tick(4);
    endtask
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        doReset(2'h2);
        rdChk(5'h09, 16'hffff, 16'h0c00);
        doReset(2'h1);
        rdChk(5'h09, 16'hffff, 16'h0300);
        for (int k = 0; k < 8; k++) begin
            w = {k[2:0], k[0] ? 5'h16 : 5'h09, 8'hff};
            gmsr_smi_model_i.wr(5'h09, w);
            tick(2);
            chk({12'h000, strobe}, (k >= 1 && k <= 4) ? 16'h0010 >> k : 16'h0000);
            chk({13'h0000, testMode_q}, {13'h0000, w[15:13]});
            chk({11'h000, ctrlBits}, {11'h000, w[12:8]});
            rdChk(5'h09, 16'hffff, {w[15:8], 8'h00});
        end
        gmsr_smi_model_i.wr(5'h09, 16'h0000);
        gmsr_smi_model_i.wr(5'h0a, 16'hffff);
        gmsr_smi_model_i.wr(5'h1f, 16'hffff);
        rdChk(5'h09, 16'hffff, 16'h0000);
        rdChk(5'h1f, 16'hffff, 16'h0000);
        pins <= 8'h16;
        tick(4);
        rdChk(5'h0a, 16'h7f00, 16'h6800);
        pins <= 8'h28;
        tick(4);
        rdChk(5'h0a, 16'h7f00, 16'h1400);
        pins <= 8'h40;
        tick(3);
        pins <= 8'h00;
        tick(4);
        rdChk(5'h06, 16'hffff, 16'h0002);
        rdChk(5'h06, 16'hffff, 16'h0000);
        pins <= 8'h01;
        tick(5);
        rdChk(5'h0a, 16'h8000, 16'h8000);
        pins <= 8'h00;
        tick(4);
        rdChk(5'h0a, 16'h8000, 16'h8000);
        rdChk(5'h0a, 16'h8000, 16'h0000);
        pulseErr(5);
        rdChk(5'h0a, 16'h00ff, 16'h0005);
        rdChk(5'h0a, 16'h00ff, 16'h0000);
        irqBase = irqCount;
        pulseErr(300);
        rdChk(5'h0a, 16'h00ff, 16'h00ff);
        chk(16'(irqCount - irqBase), 16'h002d);
        pulseErr(3);
        logicReset <= 1'h1;
        tick(1);
        logicReset <= 1'h0;
        tick(2);
        rdChk(5'h0a, 16'h00ff, 16'h0000);
        print_verdict();
    end
endmodule // gmsr_regs_tb_top
`default_nettype wire
